// ### design/mrdm_crc.v
// Running check-value accumulator over a byte stream.
`include "mrdm_defines.vh"
module mrdm_crc
(
  // Clock and reset.
  input  wire        clk,
  input  wire        rst_b,
  // Control.
  input  wire        clr,
  input  wire        en,
  input  wire [7:0]  data,
  // Result.
  output reg  [15:0] crc_q
);
  // One byte per cycle; bits are folded in least significant first.
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0]  b;
    integer i;
    reg [15:0] t;
    begin
      t = c ^ {8'h00, b};
      for (i = 0; i < 8; i = i + 1)
      begin
        if (t[0])
          t = (t >> 1) ^ `MRDM_CRC_POLY;
        else
          t = t >> 1;
      end
      crc_byte = t;
    end
  endfunction

  // Clear has priority so a new frame never inherits old state.
  always @(posedge clk)
  begin
    if (!rst_b || clr)
      crc_q <= `MRDM_CRC_INIT;
    else if (en)
      crc_q <= crc_byte(crc_q, data);
  end
endmodule

// ### design/mrdm_defines.vh
// Shared constants for the register data mapper.
`ifndef MRDM_DEFINES_VH
`define MRDM_DEFINES_VH
`define MRDM_FC_RD_HOLD    8'h03
`define MRDM_FC_RD_INPUT   8'h04
`define MRDM_FC_WR_MULTI   8'h10
`define MRDM_EXC_FLAG      8'h80
`define MRDM_EXC_ILL_FUNC  8'h01
`define MRDM_EXC_ILL_ADDR  8'h02
`define MRDM_EXC_ILL_VALUE 8'h03
`define MRDM_ADDR_MIN      8'h01
`define MRDM_ADDR_MAX      8'hF7
`define MRDM_CRC_INIT      16'hFFFF
`define MRDM_CRC_POLY      16'hA001
`define MRDM_ORD_BE        2'h0
`define MRDM_ORD_BE_WS     2'h1
`define MRDM_ORD_LE        2'h2
`define MRDM_ORD_LE_WS     2'h3
`endif

// ### design/mrdm_mapper.v
// Request interpreter: function decode, address map and reply byte ordering.
// Functional notes
// - Data split into four address-ranged blocks
// - Registers are 16-bit unsigned, fixed ranges
// - Coil and discrete blocks not served
// - Only codes 03, 04, 16 accepted
// - 03 reads holding, 04 input, 16 writes
// - Register-one offset zero or one selectable
// - 32-bit values span two registers
// - Big-endian sends most significant byte first
// - Little-endian sends least significant byte first
// - Byte swap exchanges bytes within word
// - Word swap exchanges the two words
// - Floats sent big-endian with word swap
// - Word swap ignores lone 16-bit values
// - Floats use single-precision binary format
// - Big-endian orders preferred over little-endian
// - Answer only own address, 1 to 247
// - Two-byte check value ends every frame
`include "mrdm_defines.vh"
module mrdm_mapper #(
  parameter AW       = 4,
  parameter MAX_QTY  = 8'h08
)
(
  // Clock and reset.
  input  wire          clk,
  input  wire          rst_b,
  // Configuration levels.
  input  wire [7:0]    slave_addr,
  input  wire          base_one,
  input  wire [1:0]    pair_order,
  // Received bytes of one frame, check value included.
  input  wire          rx_valid,
  input  wire [7:0]    rx_data,
  input  wire          rx_end,
  // Reply byte stream.
  output wire          tx_valid,
  output reg  [7:0]    tx_data,
  output wire          tx_last,
  input  wire          tx_ready,
  // Application loading of input registers, as 16 or 32 bits.
  input  wire          app_we,
  input  wire          app_wide,
  input  wire [AW-1:0] app_idx,
  input  wire [31:0]   app_data,
  // Application view of holding registers.
  input  wire [AW-1:0] app_rd_idx,
  output wire [15:0]   app_hold,
  // Status pulses.
  output reg           frame_err_q,
  output reg           hold_wr_q
);
  // Receive and reply states.
  localparam S_RX   = 3'h0;
  localparam S_CHK  = 3'h1;
  localparam S_HDR  = 3'h2;
  localparam S_DATA = 3'h3;
  localparam S_CRCL = 3'h4;
  localparam S_CRCH = 3'h5;
  localparam S_DROP = 3'h6;

  reg [2:0]  st_q;
  reg [7:0]  fc_q;          // Function code of the frame.
  reg [15:0] start_q;       // Requested first address.
  reg [15:0] qty_q;         // Requested register count.
  reg [7:0]  cnt_q;         // Byte position in the frame.
  reg [7:0]  exc_q;         // Exception code, zero when none.
  reg [7:0]  hi_q;          // Held high byte of a written register.
  reg [7:0]  b1_q;          // Last two bytes, candidate check value.
  reg [7:0]  b2_q;
  reg [7:0]  tx_idx_q;      // Reply byte index.
  reg [7:0]  tx_len_q;      // Reply body length before check value.
  reg [15:0] wr_err_q;      // Write guard: nonzero blocks the write.
  reg        wide_q;        // Low word of a 32-bit load is pending.
  reg [31:0] wide_v_q;
  reg [AW-1:0] wide_idx_q;  // Index that the pending low word goes to.
  reg [7:0]  hi_addr_q;     // Address byte that opened the frame.

  // Start address with the register-one offset removed.
  wire [15:0] start_adj = base_one ? start_q - 16'h0001 : start_q;
  wire        fc_ok = (fc_q == `MRDM_FC_RD_HOLD) || (fc_q == `MRDM_FC_RD_INPUT) ||
                      (fc_q == `MRDM_FC_WR_MULTI);
  wire        is_wr = (fc_q == `MRDM_FC_WR_MULTI);
  wire        range_ok = (qty_q != 16'h0000) && (qty_q <= {8'h00, MAX_QTY}) &&
                         ({1'b0, start_adj} + {1'b0, qty_q} <= (17'h00001 << AW));

  // Check value over received bytes; the last two bytes are the sender's.
  wire [15:0] rx_crc;
  wire        rx_crc_en = rx_valid && (st_q == S_RX) && (cnt_q >= 8'h02);
  wire [7:0]  rx_crc_byte = b2_q;
  mrdm_crc u_rx_crc (
    .clk   (clk),
    .rst_b (rst_b),
    .clr   (st_q == S_CHK),
    .en    (rx_crc_en),
    .data  (rx_crc_byte),
    .crc_q (rx_crc)
  );

  // Register storage; writes come from a received 16-function frame.
  // A word lands on its low byte, only for this slave and only within the count,
  // so the trailing check value bytes are stored as data only if the frame holds fewer words than its count.
  wire          wr_fire = rx_valid && (st_q == S_RX) && is_wr && fc_ok &&
                          (hi_addr_q == slave_addr) && (cnt_q >= 8'h08) && !cnt_q[0] &&
                          (cnt_q <= 8'h06 + {qty_q[6:0], 1'b0}) && (wr_err_q == 16'h0000);
  wire [AW-1:0] wr_idx = start_adj[AW-1:0] + cnt_q[AW:1] - 3'h4;
  wire [7:0]    tx_pos = tx_idx_q - 8'h01; // Register bytes pair up from index three.
  wire [AW-1:0] rd_idx = start_adj[AW-1:0] + tx_pos[AW:1] - 2'h1;
  wire [15:0]   rd_word;
  wire [AW-1:0] in_idx = wide_q ? wide_idx_q : app_idx;
  wire [15:0]   in_word;
  mrdm_regfile #(.AW(AW)) u_regs (
    .clk         (clk),
    .rst_b       (rst_b),
    .in_we       (app_we || wide_q),
    .in_idx      (in_idx),
    .in_data     (in_word),
    .hold_we     (wr_fire && (st_q == S_RX)),
    .hold_idx    (wr_idx),
    .hold_wdata  ({hi_q, rx_data}),
    .rd_sel_hold (fc_q == `MRDM_FC_RD_HOLD),
    .rd_idx      (rd_idx),
    .rd_data     (rd_word),
    .app_idx     (app_rd_idx),
    .app_hold    (app_hold)
  );

  // A 32-bit load fills two consecutive registers in the chosen order.
  function [31:0] order32;
    input [31:0] v;
    input [1:0]  o;
    begin
      case (o)
        `MRDM_ORD_BE:    order32 = v;
        `MRDM_ORD_BE_WS: order32 = {v[15:0], v[31:16]};
        `MRDM_ORD_LE:    order32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
        default:         order32 = {v[23:16], v[31:24], v[7:0], v[15:8]};
      endcase
    end
  endfunction
  // Floats keep their single-precision bit pattern untouched here; only order changes.
  wire [31:0] ord_v = order32(app_data, pair_order);
  // A lone 16-bit load sees only byte order, never word swap.
  wire [15:0] one_w = pair_order[1] ? {app_data[7:0], app_data[15:8]} : app_data[15:0];
  assign in_word = wide_q ? wide_v_q[15:0] : (app_wide ? ord_v[31:16] : one_w);

  // Second half of a wide load goes in the following cycle.
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      wide_q     <= 1'b0;
      wide_v_q   <= 32'h00000000;
      wide_idx_q <= {AW{1'b0}};
    end
    else
    begin
      wide_q     <= app_we && app_wide && !wide_q;
      wide_v_q   <= ord_v;
      wide_idx_q <= app_idx + 1'b1;
    end
  end

  // Frame intake and reply sequencing.
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_q <= S_RX;
      fc_q <= 8'h00;
      start_q <= 16'h0000;
      qty_q <= 16'h0000;
      cnt_q <= 8'h00;
      exc_q <= 8'h00;
      hi_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      tx_idx_q <= 8'h00;
      tx_len_q <= 8'h00;
      wr_err_q <= 16'h0000;
      frame_err_q <= 1'b0;
      hold_wr_q <= 1'b0;
    end
    else
    begin
      frame_err_q <= 1'b0;
      hold_wr_q <= 1'b0;
      case (st_q)
        S_RX:
        begin
          if (rx_valid)
          begin
            cnt_q <= cnt_q + 8'h01;
            b2_q <= b1_q;
            b1_q <= rx_data;
            hi_q <= rx_data;
            if (cnt_q == 8'h01)
              fc_q <= rx_data;
            if (cnt_q == 8'h02)
              start_q[15:8] <= rx_data;
            if (cnt_q == 8'h03)
              start_q[7:0] <= rx_data;
            if (cnt_q == 8'h04)
              qty_q[15:8] <= rx_data;
            if (cnt_q == 8'h05)
            begin
              qty_q[7:0] <= rx_data;
              // Guard writes before any data byte lands.
              wr_err_q <= (rx_data == 8'h00 || rx_data > MAX_QTY) ? 16'h0001 : 16'h0000;
            end
            if (cnt_q == 8'h06)
              wr_err_q <= wr_err_q | ((range_ok && fc_ok) ? 16'h0000 : 16'h0002);
            if (wr_fire)
              hold_wr_q <= 1'b1;
          end
          if (rx_end)
            st_q <= S_CHK;
        end
        S_CHK:
        begin
          cnt_q <= 8'h00;
          // Wrong address, short frame or bad check: stay silent.
          if (b1_q != rx_crc[15:8] || b2_q != rx_crc[7:0] || cnt_q < 8'h04)
          begin
            frame_err_q <= 1'b1;
            st_q <= S_RX;
          end
          else if (slave_addr < `MRDM_ADDR_MIN || slave_addr > `MRDM_ADDR_MAX ||
                   hi_addr_q != slave_addr)
            st_q <= S_RX;
          else
          begin
            // Unknown codes only earn an exception; nothing was touched.
            if (!fc_ok)
              exc_q <= `MRDM_EXC_ILL_FUNC;
            else if (!range_ok)
              exc_q <= `MRDM_EXC_ILL_ADDR;
            else
              exc_q <= 8'h00;
            tx_idx_q <= 8'h00;
            if (!fc_ok || !range_ok)
              tx_len_q <= 8'h03;
            else if (is_wr)
              tx_len_q <= 8'h06;
            else
              tx_len_q <= 8'h03 + {qty_q[6:0], 1'b0};
            st_q <= S_HDR;
          end
        end
        S_HDR, S_DATA:
        begin
          if (tx_ready)
          begin
            tx_idx_q <= tx_idx_q + 8'h01;
            if (tx_idx_q == tx_len_q - 8'h01)
              st_q <= S_CRCL;
            else if (tx_idx_q == 8'h02)
              st_q <= S_DATA;
          end
        end
        S_CRCL:
          if (tx_ready)
            st_q <= S_CRCH;
        S_CRCH:
          if (tx_ready)
            st_q <= S_RX;
        default:
          st_q <= S_RX;
      endcase
    end
  end

  // First byte of the frame is the addressed slave.
  always @(posedge clk)
  begin
    if (!rst_b)
      hi_addr_q <= 8'h00;
    else if (rx_valid && st_q == S_RX && cnt_q == 8'h00)
      hi_addr_q <= rx_data;
  end

  // Reply check value runs over each byte as it is accepted.
  wire [15:0] tx_crc;
  mrdm_crc u_tx_crc (
    .clk   (clk),
    .rst_b (rst_b),
    .clr   (st_q == S_CHK),
    .en    (tx_ready && (st_q == S_HDR || st_q == S_DATA)),
    .data  (tx_data),
    .crc_q (tx_crc)
  );

  // Reply byte selection; register words go high byte first.
  always @*
  begin
    tx_data = 8'h00;
    case (st_q)
      S_CRCL: tx_data = tx_crc[7:0];
      S_CRCH: tx_data = tx_crc[15:8];
      default:
      begin
        if (tx_idx_q == 8'h00)
          tx_data = hi_addr_q;
        else if (tx_idx_q == 8'h01)
          tx_data = (exc_q != 8'h00) ? (fc_q | `MRDM_EXC_FLAG) : fc_q;
        else if (exc_q != 8'h00)
          tx_data = exc_q;
        else if (is_wr)
          case (tx_idx_q)
            8'h02:   tx_data = start_q[15:8];
            8'h03:   tx_data = start_q[7:0];
            8'h04:   tx_data = qty_q[15:8];
            default: tx_data = qty_q[7:0];
          endcase
        else if (tx_idx_q == 8'h02)
          tx_data = {qty_q[6:0], 1'b0};
        else
          tx_data = tx_idx_q[0] ? rd_word[15:8] : rd_word[7:0];
      end
    endcase
  end

  // Big-endian orders are the reset-free default the integrator should keep.
  assign tx_valid = (st_q == S_HDR) || (st_q == S_DATA) || (st_q == S_CRCL) ||
                    (st_q == S_CRCH);
  assign tx_last  = (st_q == S_CRCH);
endmodule

// ### design/mrdm_regfile.v
// Flip-flop storage for input and holding registers.
`include "mrdm_defines.vh"
module mrdm_regfile #(
  parameter AW = 4
)
(
  // Clock and reset.
  input  wire          clk,
  input  wire          rst_b,
  // Application side loads input registers.
  input  wire          in_we,
  input  wire [AW-1:0] in_idx,
  input  wire [15:0]   in_data,
  // Protocol side write port for holding registers.
  input  wire          hold_we,
  input  wire [AW-1:0] hold_idx,
  input  wire [15:0]   hold_wdata,
  // Read port: sel high picks holding, low picks input.
  input  wire          rd_sel_hold,
  input  wire [AW-1:0] rd_idx,
  output wire [15:0]   rd_data,
  // Application view of a holding register.
  input  wire [AW-1:0] app_idx,
  output wire [15:0]   app_hold
);
  localparam N = 1 << AW;
  reg [15:0] inp_q  [0:N-1]; // Input registers, 16-bit unsigned.
  reg [15:0] hold_q [0:N-1]; // Holding registers, 16-bit unsigned.
  integer k;

  // Both blocks clear at reset; each holds 0..65535.
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      for (k = 0; k < N; k = k + 1)
      begin
        inp_q[k]  <= 16'h0000;
        hold_q[k] <= 16'h0000;
      end
    end
    else
    begin
      if (in_we)
        inp_q[in_idx] <= in_data;
      if (hold_we)
        hold_q[hold_idx] <= hold_wdata;
    end
  end

  assign rd_data  = rd_sel_hold ? hold_q[rd_idx] : inp_q[rd_idx];
  assign app_hold = hold_q[app_idx];
endmodule

// ### tb/mrdm_mapper_monitor.sv
// Checker of the mapper's reply handshake, decode and status pulses.
module mrdm_mapper_chk
(
  // Clock, reset and own address.
  input logic       clk,
  input logic       rst_b,
  input logic [7:0] slave_addr,
  // Request and reply streams.
  input logic       rx_valid,
  input logic [7:0] rx_data,
  input logic       rx_end,
  input logic       tx_valid,
  input logic [7:0] tx_data,
  input logic       tx_last,
  input logic       tx_ready,
  // Status pulses.
  input logic       frame_err_q,
  input logic       hold_wr_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [1:0] rxn_q;  // Request bytes seen, saturating at two.
  logic [7:0] fc_q;   // Function code of the current request.
  logic [4:0] txn_q;  // Index of the reply byte on offer.
  wire bad_fc = fc_q != 8'h03 && fc_q != 8'h04 && fc_q != 8'h10;
  // Track the code and the reply index; the code is held until the next frame's second byte arrives.
  always @(posedge clk)
  begin
    if (!rst_b || rx_end) rxn_q <= 2'h0;
    else if (rx_valid && rxn_q != 2'h2) rxn_q <= rxn_q + 2'h1;
    if (!rst_b) fc_q <= 8'h00;
    else if (rx_valid && rxn_q == 2'h1) fc_q <= rx_data;
    if (!rst_b) txn_q <= 5'h00;
    else if (tx_valid && tx_ready) txn_q <= tx_last ? 5'h00 : txn_q + 5'h01;
  end
  sequence s_stall; tx_valid && !tx_ready; endsequence
  sequence s_final; tx_valid && tx_ready && tx_last; endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !tx_valid)
    else $error("reply offered after reset");
  a_data_stands: assert property (s_stall |=> tx_valid && $stable(tx_data))
    else $error("reply byte changed while stalled");
  a_final_drop: assert property (s_final |=> !tx_valid [*2])
    else $error("reply continued after last byte");
  a_last_valid: assert property (tx_last |-> tx_valid)
    else $error("last flag without a byte");
  a_reply_timing: assert property ($rose(tx_valid) |-> $past(rx_end, 2))
    else $error("reply start not two cycles after frame end");
  a_reply_addr: assert property ($rose(tx_valid) |-> tx_data == slave_addr)
    else $error("reply does not open with own address");
  a_exc_func: assert property (tx_valid && txn_q == 5'h01 && bad_fc |-> tx_data == (fc_q | 8'h80))
    else $error("illegal code not flagged");
  a_exc_code: assert property (tx_valid && txn_q == 5'h02 && bad_fc |-> tx_data == 8'h01)
    else $error("wrong exception code");
  a_good_func: assert property (tx_valid && txn_q == 5'h01 && !bad_fc |-> tx_data[6:0] == fc_q[6:0])
    else $error("reply code differs from request");
  a_hold_code: assert property (hold_wr_q |-> fc_q == 8'h10)
    else $error("holding write without write code");
  a_hold_pulse: assert property (hold_wr_q |=> !hold_wr_q)
    else $error("write pulse longer than one cycle");
  a_err_quiet: assert property (frame_err_q |-> !tx_valid [*4])
    else $error("reply after bad check value");
endmodule

bind mrdm_mapper mrdm_mapper_chk u_mrdm_mapper_chk (.clk(clk), .rst_b(rst_b),
  .slave_addr(slave_addr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
  .frame_err_q(frame_err_q), .hold_wr_q(hold_wr_q));

// ### tb/mrdm_master_model.sv
// Bus master model: frames requests with a check value and gathers replies.
module mrdm_master_model
(
  // Clock.
  input  logic       clk,
  // Request bytes towards the mapper.
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       rx_end,
  // Reply bytes from the mapper.
  input  logic       tx_valid,
  input  logic [7:0] tx_data,
  input  logic       tx_last,
  output logic       tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] req_q[$];  // Request body; the check value is added on send.
  logic [7:0] rsp_q[$];  // Reply bytes as taken.
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    tx_ready = 1'b0;
  end
  // Reflected check over a byte queue.
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // Send, then take the reply; ready is high one cycle in stall+1 to test holding.
  task automatic transact(input int stall, input bit bad, output bit got);
    logic [15:0] c;
    c = crc16(req_q);
    req_q.push_back(c[7:0] ^ {7'h00, bad});
    req_q.push_back(c[15:8]);
    rsp_q = {};
    got = 1'b0;
    foreach (req_q[i])
    begin
      @(posedge clk);
      #2 rx_valid = 1'b1;
      rx_data = req_q[i];
    end
    @(posedge clk);
    #2 rx_valid = 1'b0;
    rx_end = 1'b1;
    rx_data = ~rx_data;  // A released line must not look like the last byte.
    @(posedge clk);
    #2 rx_end = 1'b0;
    for (int i = 0; i < 80 && !got; i++)
    begin
      tx_ready = (i % (stall + 1)) == stall;
      @(posedge clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
      begin
        rsp_q.push_back(tx_data);
        got = tx_last;
      end
      #2;
    end
    tx_ready = 1'b0;
    req_q = {};
  endtask
endmodule

// ### tb/test_mrdm_mapper.sv
// Self-checking bench for the register data mapper.
module test_mrdm_mapper;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] SA = 8'h2A;  // Own address used throughout.
  logic        clk, rst_b, base_one, app_we, app_wide;
  logic [7:0]  slave_addr;
  logic [1:0]  pair_order;
  logic [3:0]  app_idx, app_rd_idx;
  logic [31:0] app_data;
  logic        rx_valid, rx_end, tx_valid, tx_last, tx_ready, frame_err_q, hold_wr_q;
  logic [7:0]  rx_data, tx_data;
  logic [15:0] app_hold;
  logic [7:0]  exp_q[$];  // Expected reply without check value.
  int          err_total, samples_checked, cycles, err_seen, wr_seen;
  mrdm_mapper #(.AW(4)) u_mrdm_mapper (.clk(clk), .rst_b(rst_b), .slave_addr(slave_addr),
    .base_one(base_one), .pair_order(pair_order), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .app_we(app_we), .app_wide(app_wide), .app_idx(app_idx),
    .app_data(app_data), .app_rd_idx(app_rd_idx), .app_hold(app_hold),
    .frame_err_q(frame_err_q), .hold_wr_q(hold_wr_q));
  mrdm_master_model u_mrdm_master_model (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Count check-value failures and cut a hang short.
  always @(posedge clk)
  begin
    cycles++;
    if (frame_err_q === 1'b1) err_seen++;
    if (hold_wr_q === 1'b1) wr_seen++;
    if (cycles == 20000)
    begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Seal the expected reply with its check value and compare byte by byte.
  task automatic check_reply();
    logic [15:0] c;
    c = u_mrdm_master_model.crc16(exp_q);
    exp_q.push_back(c[7:0]);
    exp_q.push_back(c[15:8]);
    check_val(16'(u_mrdm_master_model.rsp_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i])
      if (i < u_mrdm_master_model.rsp_q.size())
        check_val({8'h00, u_mrdm_master_model.rsp_q[i]}, {8'h00, exp_q[i]});
    exp_q = {};
  endtask
  task automatic load(input logic wide, input logic [3:0] idx, input logic [31:0] data);
    @(posedge clk);
    #2 app_we = 1'b1;
    app_wide = wide;
    app_idx = idx;
    app_data = data;
    @(posedge clk);
    #2 app_we = 1'b0;
  endtask
  task automatic req(input logic [7:0] fc, input logic [7:0] lo, input logic [7:0] qty);
    u_mrdm_master_model.req_q = {SA, fc, 8'h00, lo, 8'h00, qty};
  endtask
  task automatic xfer(input int stall, input bit bad, output bit got);
    u_mrdm_master_model.transact(stall, bad, got);
  endtask
  // Every pair order on a wide value and a lone word read in one reply.
  task automatic test_orders();
    logic [47:0] tab [4];
    bit got;
    tab = '{48'h0D0C0B0A0E0F, 48'h0B0A0D0C0E0F, 48'h0A0B0C0D0F0E, 48'h0C0D0A0B0F0E};
    for (int o = 0; o < 4; o++)
    begin
      pair_order = 2'(o);
      load(1'b1, 4'h2, 32'h0D0C0B0A);
      load(1'b0, 4'h4, 32'h00000E0F);
      req(8'h04, 8'h02, 8'h03);
      xfer(o, 1'b0, got);
      exp_q = {SA, 8'h04, 8'h06};
      for (int k = 5; k >= 0; k--) exp_q.push_back(tab[o][k*8 +: 8]);
      check_reply();
    end
  endtask
  // Multi-register write with address one as the first register, then read back.
  task automatic test_write();
    bit got;
    int wrs;
    wrs = wr_seen;
    pair_order = 2'h0;
    base_one = 1'b1;
    u_mrdm_master_model.req_q = {SA, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04,
                                 8'h12, 8'h34, 8'hAB, 8'hCD};
    xfer(1, 1'b0, got);
    exp_q = {SA, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02};
    check_reply();
    check_val(16'(wr_seen - wrs), 16'h0002);
    app_rd_idx = 4'h0;
    #1 check_val(app_hold, 16'h1234);
    app_rd_idx = 4'h1;
    #1 check_val(app_hold, 16'hABCD);
    base_one = 1'b0;
    req(8'h03, 8'h00, 8'h02);
    xfer(0, 1'b0, got);
    exp_q = {SA, 8'h03, 8'h04, 8'h12, 8'h34, 8'hAB, 8'hCD};
    check_reply();
  endtask
  // Unsupported codes, including single writes, must leave registers alone.
  task automatic test_bad_code();
    logic [7:0] codes [5];
    bit got;
    int wrs;
    wrs = wr_seen;
    codes = '{8'h01, 8'h02, 8'h05, 8'h06, 8'h0F};
    foreach (codes[i])
    begin
      u_mrdm_master_model.req_q = {SA, codes[i], 8'h00, 8'h00, 8'hFF, 8'hFF};
      xfer(0, 1'b0, got);
      exp_q = {SA, codes[i] | 8'h80, 8'h01};
      check_reply();
    end
    app_rd_idx = 4'h0;
    #1 check_val(app_hold, 16'h1234);
    check_val(16'(wr_seen - wrs), 16'h0000);
  endtask
  // Foreign address and bad check stay silent; out-of-range reads are refused.
  task automatic test_refused();
    bit got;
    int errs;
    errs = err_seen;
    u_mrdm_master_model.req_q = {SA + 8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01};
    xfer(0, 1'b0, got);
    check_val(16'(got), 16'h0000);
    // A write for another slave must leave holding register 0 untouched.
    u_mrdm_master_model.req_q = {SA + 8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02,
                                 8'h55, 8'h66};
    xfer(0, 1'b0, got);
    app_rd_idx = 4'h0;
    #1 check_val(app_hold, 16'h1234);
    req(8'h04, 8'h00, 8'h01);
    xfer(0, 1'b1, got);
    check_val(16'(got), 16'h0000);
    check_val(16'(err_seen - errs), 16'h0001);
    req(8'h04, 8'h0F, 8'h02);
    xfer(0, 1'b0, got);
    exp_q = {SA, 8'h84, 8'h02};
    check_reply();
  endtask
  initial
  begin
    rst_b = 1'b0;
    slave_addr = SA;
    base_one = 1'b0;
    pair_order = 2'h0;
    app_we = 1'b0;
    app_wide = 1'b0;
    app_idx = 4'h0;
    app_data = 32'h00000000;
    app_rd_idx = 4'h0;
    repeat (12) @(posedge clk);
    #2 rst_b = 1'b1;
    test_orders();
    test_write();
    test_bad_code();
    test_refused();
    give_verdict();
  end
endmodule
